// ---- include/clss_pkg.sv ----
// constants, field layout and types shared by the loopback/self-sync block
// assumes a 32-bit apb register bus on pclk and a 32-bit, 4-lane word stream
`default_nettype none
package clss_pkg;
	localparam logic [11:0] CLSS_OFF_LOOP   = 12'h000;
	localparam logic [11:0] CLSS_OFF_L1     = 12'h004;
	localparam logic [11:0] CLSS_OFF_STAT   = 12'h008;
	localparam int          CLSS_FWD_LSB    = 0;
	localparam int          CLSS_REV_LSB    = 4;
	localparam int          CLSS_FORCE_BIT  = 0;
	localparam int          CLSS_SLAVE_BIT  = 1;
	localparam logic [1:0]  CLSS_RST_FWD    = 2'h0;
	localparam logic [3:0]  CLSS_RST_REV    = 4'h0;
	localparam logic        CLSS_RST_FORCE  = 1'h0;
	localparam logic        CLSS_RST_SLAVE  = 1'h0;
	localparam logic [7:0]  CLSS_K285       = 8'hbc;
	localparam logic [31:0] CLSS_IDLE_WORD  = 32'h000000bc;
	localparam logic [3:0]  CLSS_IDLE_K     = 4'h1;
	localparam int          CLSS_WR_LAT     = 2;
	localparam int          CLSS_FIFO_DEPTH = 4;

	typedef enum logic [1:0] {
		CLSS_FWD_NONE,
		CLSS_FWD_SERIAL,
		CLSS_FWD_PAR_STITCH,
		CLSS_FWD_PAR_DIRECT
	} clss_fwd_t;

	typedef enum logic {
		CLSS_HUNT,
		CLSS_LOCKED
	} clss_lock_t;
endpackage : clss_pkg
`default_nettype wire

// ---- include/clss_fifo_if.sv ----
// valid/ready carrier between the transmit buffer and its two sides
// assumes both sides run on the same clock
`default_nettype none
interface clss_fifo_if #(parameter int W = 36) ();
	logic [W-1:0] wdata;
	logic         wvalid;
	logic         wready;
	logic [W-1:0] rdata;
	logic         rvalid;
	logic         rready;
	modport src  (output wdata, output wvalid, input wready);
	modport snk  (input rdata, input rvalid, output rready);
	modport fifo (input wdata, input wvalid, input rready,
		output wready, output rdata, output rvalid);
endinterface : clss_fifo_if
`default_nettype wire

// ---- design/clss_fifo.sv ----
// small register-array fifo with valid/ready on both sides
// assumes depth is a power of two
`default_nettype none
module clss_fifo #(
	parameter int W     = 36,
	parameter int DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	clss_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wptr;
	logic [AW:0]  rptr;
	logic         full;
	logic         empty;

	assign empty    = (wptr == rptr);
	assign full     = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
	assign f.wready = !full;
	assign f.rvalid = !empty;
	assign f.rdata  = mem[rptr[AW-1:0]];

	always_ff @(posedge pclk) begin
		if (f.wvalid && !full)
			mem[wptr[AW-1:0]] <= f.wdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr <= '0;
			rptr <= '0;
		end else begin
			if (f.wvalid && !full)
				wptr <= wptr + 1'b1;
			if (f.rready && !empty)
				rptr <= rptr + 1'b1;
		end
	end
endmodule : clss_fifo
`default_nettype wire

// ---- design/clss_top.sv ----
// loopback path selection and transmit sync override for the link word path
// assumes words on pclk, an apb master, and stitching logic that accepts tx words
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`default_nettype none
module clss_top #(
	parameter bit P_SER_LB     = 1'b1,
	parameter bit P_PAR_LB     = 1'b1,
	parameter bit P_REV_LB     = 1'b1,
	parameter int P_WR_LAT     = clss_pkg::CLSS_WR_LAT,
	parameter int P_FIFO_DEPTH = clss_pkg::CLSS_FIFO_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] app_tx_data,
	input  wire logic [3:0]  app_tx_k,
	input  wire logic        app_tx_valid,
	output logic             app_tx_ready,
	input  wire logic        dir_wr_en,
	input  wire logic [31:0] dir_wr_data,
	input  wire logic        ser_tx_ready,
	output logic      [31:0] ser_tx_data,
	output logic      [3:0]  ser_tx_k,
	output logic             serial_loop_en,
	input  wire logic [31:0] ser_rx_data,
	input  wire logic [3:0]  ser_rx_k,
	input  wire logic        cdr_locked,
	output logic      [31:0] app_rx_data,
	output logic      [3:0]  app_rx_k,
	output logic             app_rx_valid
);
	// control fields
	logic [1:0]  loop_fwd;
	logic [3:0]  loop_rev;
	logic        tx_sync_force;
	logic        role_slave;
	logic [31:0] next_prdata;
	// effective modes
	logic        par_stitch;
	logic        par_direct;
	logic        rev_active;
	// receive side
	logic [2:0]  cdr_ff;
	logic        cdr_stable;
	logic [31:0] rx_src_data;
	logic [3:0]  rx_src_k;
	clss_pkg::clss_lock_t lock_st;
	logic        rx_locked;
	logic        rx_has_k285;
	// transmit side
	logic        tx_enabled;
	logic [31:0] local_word;
	logic [3:0]  local_k;
	logic [31:0] next_tx_data;
	logic [3:0]  next_tx_k;
	logic [31:0] tx_pre_data;
	logic [3:0]  tx_pre_k;
	// direct write delay line
	logic        dly_en_pipe   [P_WR_LAT+1];
	logic [31:0] dly_data_pipe [P_WR_LAT+1];
	logic        dly_en;
	logic [31:0] dly_data;
	clss_fifo_if #(.W(36)) txq ();
	function automatic logic reg_mapped(input logic [11:0] a);
		reg_mapped = (a == clss_pkg::CLSS_OFF_LOOP) || (a == clss_pkg::CLSS_OFF_L1)
			|| (a == clss_pkg::CLSS_OFF_STAT);
	endfunction : reg_mapped

	// ---------------- apb slave ----------------
	// zero wait states; unmapped addresses answer with pslverr and read zero
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !reg_mapped(paddr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_fwd      <= clss_pkg::CLSS_RST_FWD;
			loop_rev      <= clss_pkg::CLSS_RST_REV;
			tx_sync_force <= clss_pkg::CLSS_RST_FORCE;
			role_slave    <= clss_pkg::CLSS_RST_SLAVE;
		end else if (psel && penable && pwrite) begin
			if (paddr == clss_pkg::CLSS_OFF_LOOP) begin
				loop_fwd <= pwdata[clss_pkg::CLSS_FWD_LSB +: 2];
				loop_rev <= pwdata[clss_pkg::CLSS_REV_LSB +: 4];
			end
			if (paddr == clss_pkg::CLSS_OFF_L1) begin
				tx_sync_force <= pwdata[clss_pkg::CLSS_FORCE_BIT];
				role_slave    <= pwdata[clss_pkg::CLSS_SLAVE_BIT];
			end
		end
	end

	always_comb begin
		next_prdata = 32'h00000000;
		if (reg_mapped(paddr)) begin
			case (paddr)
				clss_pkg::CLSS_OFF_LOOP: begin
					next_prdata[clss_pkg::CLSS_FWD_LSB +: 2] = loop_fwd;
					next_prdata[clss_pkg::CLSS_REV_LSB +: 4] = loop_rev;
				end
				clss_pkg::CLSS_OFF_L1: begin
					next_prdata[clss_pkg::CLSS_FORCE_BIT] = tx_sync_force;
					next_prdata[clss_pkg::CLSS_SLAVE_BIT] = role_slave;
				end
				clss_pkg::CLSS_OFF_STAT: begin
					next_prdata[0] = rx_locked;
					next_prdata[1] = tx_enabled;
					next_prdata[2] = !txq.wready;
					next_prdata[3] = !txq.rvalid;
					next_prdata[4] = serial_loop_en;
					next_prdata[5] = par_stitch;
					next_prdata[6] = par_direct;
					next_prdata[7] = rev_active;
				end
				default: next_prdata = 32'h00000000;
			endcase
		end
	end

	// read data latched in the setup cycle so the access cycle sees a register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable)
			prdata <= next_prdata;
	end

	// ---------------- loopback mode decode ----------------
	// a select for a path that was not built falls back to normal operation
	assign par_stitch = P_PAR_LB && (loop_fwd == clss_pkg::CLSS_FWD_PAR_STITCH);
	assign par_direct = P_PAR_LB && (loop_fwd == clss_pkg::CLSS_FWD_PAR_DIRECT);
	assign rev_active = P_REV_LB && (loop_rev != 4'h0);

	// registered so the transceiver control never sees decode glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			serial_loop_en <= 1'b0;
		else
			serial_loop_en <= P_SER_LB && (loop_fwd == clss_pkg::CLSS_FWD_SERIAL);
	end

	// ---------------- cdr lock pin synchroniser ----------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cdr_ff <= 3'h0;
		else
			cdr_ff <= {cdr_ff[1:0], cdr_locked};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cdr_stable <= 1'b0;
		else if (cdr_ff[1] == cdr_ff[2])
			cdr_stable <= cdr_ff[2];
	end

	// ---------------- receive source selection ----------------
	always_comb begin
		rx_src_data = ser_rx_data;
		rx_src_k    = ser_rx_k;
		if (par_direct) begin
			rx_src_data = tx_pre_data;
			rx_src_k    = tx_pre_k;
		end else if (par_stitch) begin
			rx_src_data = ser_tx_data;
			rx_src_k    = ser_tx_k;
		end
	end

	assign rx_has_k285 = rx_src_k[0] && (rx_src_data[7:0] == clss_pkg::CLSS_K285);

	// parallel loops bypass the transceiver, so cdr lock is not needed there
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_st <= clss_pkg::CLSS_HUNT;
		end else begin
			case (lock_st)
				clss_pkg::CLSS_HUNT:
					if ((cdr_stable || par_stitch || par_direct) && rx_has_k285)
						lock_st <= clss_pkg::CLSS_LOCKED;
				clss_pkg::CLSS_LOCKED:
					if (!cdr_stable && !par_stitch && !par_direct)
						lock_st <= clss_pkg::CLSS_HUNT;
				default: lock_st <= clss_pkg::CLSS_HUNT;
			endcase
		end
	end

	assign rx_locked = (lock_st == clss_pkg::CLSS_LOCKED);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			app_rx_data  <= 32'h00000000;
			app_rx_k     <= 4'h0;
			app_rx_valid <= 1'b0;
		end else begin
			app_rx_data  <= rx_src_data;
			app_rx_k     <= rx_src_k;
			app_rx_valid <= rx_locked;
		end
	end

	// ---------------- transmit enable ----------------
	// a slave waits for receive lock unless forced; the force is a layer 1
	// test aid only, higher layers see sync that no peer produced
	assign tx_enabled = !role_slave || rx_locked || tx_sync_force;

	// ---------------- transmit buffer ----------------
	assign txq.wdata    = {app_tx_k, app_tx_data};
	assign txq.wvalid   = app_tx_valid;
	assign app_tx_ready = txq.wready;
	// a delayed direct write takes the slot, so the buffer holds its word
	assign txq.rready   = tx_enabled && ser_tx_ready && !dly_en;

	clss_fifo #(
		.W     (36),
		.DEPTH (P_FIFO_DEPTH)
	) u_txq (
		.pclk    (pclk),
		.presetn (presetn),
		.f       (txq.fifo)
	);

	// ---------------- direct write latency line ----------------
	assign dly_en_pipe[0]   = dir_wr_en;
	assign dly_data_pipe[0] = dir_wr_data;

	generate
		for (genvar i = 1; i <= P_WR_LAT; i++) begin : g_dly
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					dly_en_pipe[i]   <= 1'b0;
					dly_data_pipe[i] <= 32'h00000000;
				end else begin
					dly_en_pipe[i]   <= dly_en_pipe[i-1];
					dly_data_pipe[i] <= dly_data_pipe[i-1];
				end
			end
		end
	endgenerate

	assign dly_en   = dly_en_pipe[P_WR_LAT];
	assign dly_data = dly_data_pipe[P_WR_LAT];

	// ---------------- local transmit word ----------------
	always_comb begin
		local_word = 32'h00000000;
		local_k    = 4'h0;
		if (tx_enabled) begin
			if (dly_en) begin
				local_word = dly_data;
			end else if (txq.rvalid && txq.rready) begin
				local_word = txq.rdata[31:0];
				local_k    = txq.rdata[35:32];
			end else begin
				local_word = clss_pkg::CLSS_IDLE_WORD;
				local_k    = clss_pkg::CLSS_IDLE_K;
			end
		end
	end

	// per-lane reverse mux: while tx is enabled, selected lanes from rx, the rest local
	generate
		for (genvar n = 0; n < 4; n++) begin : g_lane
			always_comb begin
				if (tx_enabled && rev_active && loop_rev[n]) begin
					next_tx_data[8*n +: 8] = ser_rx_data[8*n +: 8];
					next_tx_k[n]           = ser_rx_k[n];
				end else begin
					next_tx_data[8*n +: 8] = local_word[8*n +: 8];
					next_tx_k[n]           = local_k[n];
				end
			end
		end
	endgenerate

	// tx_pre is the word entering stitching; ser_tx is the stitched word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pre_data <= 32'h00000000;
			tx_pre_k    <= 4'h0;
			ser_tx_data <= 32'h00000000;
			ser_tx_k    <= 4'h0;
		end else begin
			tx_pre_data <= next_tx_data;
			tx_pre_k    <= next_tx_k;
			ser_tx_data <= tx_pre_data;
			ser_tx_k    <= tx_pre_k;
		end
	end

	// ---------------- checks ----------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_serial_sel;
		(loop_fwd == 2'h1) |=> (serial_loop_en == P_SER_LB);
	endproperty
	a_serial_sel: assert property (p_serial_sel)
		else $error("serial loopback enable does not follow select");

	property p_par_stitch;
		par_stitch |=> (app_rx_data == $past(ser_tx_data)) && (app_rx_k == $past(ser_tx_k));
	endproperty
	a_par_stitch: assert property (p_par_stitch)
		else $error("stitched parallel loopback data mismatch");
	property p_par_direct;
		par_direct |=> (app_rx_data == $past(tx_pre_data));
	endproperty
	a_par_direct: assert property (p_par_direct)
		else $error("direct parallel loopback data mismatch");
	property p_rev_sel;
		(tx_enabled && rev_active && loop_rev[0])
			|=> (tx_pre_data[7:0] == $past(ser_rx_data[7:0]));
	endproperty
	a_rev_sel: assert property (p_rev_sel)
		else $error("selected lane not looped back");
	property p_rev_local;
		(tx_enabled && rev_active && !loop_rev[1])
			|=> (tx_pre_data[15:8] == $past(local_word[15:8]));
	endproperty
	a_rev_local: assert property (p_rev_local)
		else $error("unselected lane not filled locally");
	property p_rev_absent;
		// sampled reset keeps the release edge, still reset inside, out of the check
		(presetn && (!P_REV_LB || loop_rev == 4'h0)) |=> (tx_pre_data == $past(local_word))
			&& (tx_pre_k == $past(local_k));
	endproperty
	a_rev_absent: assert property (p_rev_absent)
		else $error("reverse field changed tx without reverse path");

	property p_master_sync;
		(!role_slave && !rev_active && !txq.rvalid && !dly_en)
			|-> ##2 (ser_tx_data[7:0] == 8'hbc) && ser_tx_k[0];
	endproperty
	a_master_sync: assert property (p_master_sync)
		else $error("master did not send K28.5");
	property p_slave_hold;
		(role_slave && !tx_sync_force && !rx_locked) |-> ##2 (ser_tx_k == 4'h0);
	endproperty
	a_slave_hold: assert property (p_slave_hold)
		else $error("slave sent control characters before lock");
	property p_slave_force;
		(role_slave && tx_sync_force && !rx_locked && !rev_active && !txq.rvalid && !dly_en)
			|-> ##2 (ser_tx_data[7:0] == 8'hbc) && ser_tx_k[0];
	endproperty
	a_slave_force: assert property (p_slave_force)
		else $error("forced slave did not send K28.5");

	property p_wr_lat;
		(dly_en == $past(dir_wr_en, P_WR_LAT)) && (dly_data == $past(dir_wr_data, P_WR_LAT));
	endproperty
	a_wr_lat: assert property (p_wr_lat)
		else $error("direct write latency wrong");

	property p_no_loop;
		(presetn && loop_fwd == 2'h0 && loop_rev == 4'h0) |=> !serial_loop_en
			&& (app_rx_data == $past(ser_rx_data)) && (tx_pre_data == $past(local_word));
	endproperty
	a_no_loop: assert property (p_no_loop)
		else $error("loopback active with both selects clear");
endmodule : clss_top
`default_nettype wire

// ---- bench/clss_peer.sv ----
// far-side transceiver model: echoes tx words while looped, else injected or toggling rx
// assumes the block's clock; cdr lock follows the loop state
`default_nettype none
module clss_peer (
	input  wire logic        pclk,
	input  wire logic [31:0] tx_data,
	input  wire logic [3:0]  tx_k,
	input  wire logic        loop_en,
	input  wire logic        inj_en,
	input  wire logic [31:0] inj_data,
	output logic      [31:0] rx_data,
	output logic      [3:0]  rx_k,
	output logic             cdr_locked
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_data = 32'h0;
		rx_k = 4'h0;
		cdr_locked = 1'b0;
	end
	// an idle line toggles so a stale word never passes for data
	always @(posedge pclk) begin
		cdr_locked <= loop_en;
		rx_k <= loop_en ? tx_k : 4'h0;
		rx_data <= loop_en ? tx_data : (inj_en ? inj_data : ~rx_data);
	end
endmodule : clss_peer
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the loopback and tx sync override block
// assumes apb zero-wait slave and the far-side model on the word path
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WL = 2;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, app_tx_data, dir_wr_data, ser_tx_data, ser_rx_data;
	logic [31:0] app_rx_data, inj_d;
	logic [3:0]  app_tx_k, ser_tx_k, ser_rx_k, app_rx_k;
	logic        app_tx_valid, app_tx_ready, dir_wr_en, ser_tx_ready, serial_loop_en;
	logic        cdr_locked, app_rx_valid, inj_en;
	int          err_total, check_count, cyc;

	clss_top #(.P_WR_LAT(WL)) i_clss_top (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .app_tx_data, .app_tx_k,
		.app_tx_valid, .app_tx_ready, .dir_wr_en, .dir_wr_data, .ser_tx_ready,
		.ser_tx_data, .ser_tx_k, .serial_loop_en, .ser_rx_data, .ser_rx_k, .cdr_locked,
		.app_rx_data, .app_rx_k, .app_rx_valid);
	clss_peer i_clss_peer (.pclk, .tx_data(ser_tx_data), .tx_k(ser_tx_k),
		.loop_en(serial_loop_en), .inj_en, .inj_data(inj_d), .rx_data(ser_rx_data),
		.rx_k(ser_rx_k), .cdr_locked);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task end_of_test;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_of_test;
		end
	end

	task chk(input string n, input logic [35:0] s, input logic [35:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [32:0] r;
		apb(1'b1, a, d, r);
	endtask : wr

	task rd_chk(input string n, input logic [11:0] a, input logic [32:0] e);
		logic [32:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(n, {3'h0, r}, {3'h0, e});
	endtask : rd_chk

	// bounded wait: 0 = ser_tx word, 1 = app_rx word, 2 = app_rx_valid
	task wait_sig(input string n, input int sel, input logic [35:0] e);
		logic [35:0] v;
		for (int i = 0; i < 24; i++) begin
			@(negedge pclk);
			v = sel == 0 ? {ser_tx_k, ser_tx_data} :
				sel == 1 ? {app_rx_k, app_rx_data} : {35'h0, app_rx_valid};
			if (v === e) break;
		end
		chk(n, v, e);
	endtask : wait_sig

	task push(input logic [31:0] d);
		@(posedge pclk);
		app_tx_valid <= 1'b1;
		app_tx_data <= d;
		@(posedge pclk);
		app_tx_valid <= 1'b0;
	endtask : push

	task t_reset;
		rd_chk("loop_reg", clss_pkg::CLSS_OFF_LOOP, 33'h0);
		rd_chk("l1_reg", clss_pkg::CLSS_OFF_L1, 33'h0);
		rd_chk("status", clss_pkg::CLSS_OFF_STAT, 33'h0000_000a);
		rd_chk("unmapped", 12'h010, 33'h1_0000_0000);
		chk("serial_loop_en", {35'h0, serial_loop_en}, 36'h0);
		chk("pready", {35'h0, pready}, 36'h1);
		wait_sig("master_idle", 0, {4'h1, 32'h0000_00bc});
	endtask : t_reset

	task t_direct;
		@(posedge pclk);
		dir_wr_en <= 1'b1;
		dir_wr_data <= 32'hc3a5_0f1e;
		@(posedge pclk);
		dir_wr_en <= 1'b0;
		// the word reaches ser_tx at the edge wl+1 after the one that took it
		repeat (WL + 1) begin
			@(negedge pclk);
			chk("direct_early", {35'h0, ser_tx_data === 32'hc3a5_0f1e}, 36'h0);
		end
		@(negedge pclk);
		chk("direct", {ser_tx_k, ser_tx_data}, {4'h0, 32'hc3a5_0f1e});
	endtask : t_direct

	task t_fifo;
		int n;
		n = 0;
		@(posedge pclk);
		ser_tx_ready <= 1'b0;
		@(posedge pclk);
		app_tx_valid <= 1'b1;
		app_tx_data <= 32'ha0a0_a0a0;
		repeat (8) begin
			@(posedge pclk);
			if (app_tx_ready === 1'b1) begin
				n++;
				app_tx_data <= 32'ha0a0_a0a0 + n;
			end
		end
		app_tx_valid <= 1'b0;
		chk("accepted", n, 36'd4);
		rd_chk("status_full", clss_pkg::CLSS_OFF_STAT, 33'h0000_0006);
		@(negedge pclk);
		chk("stall_idle", {ser_tx_k, ser_tx_data}, {4'h1, 32'h0000_00bc});
		@(posedge pclk);
		ser_tx_ready <= 1'b1;
		for (int i = 0; i < 4; i++)
			wait_sig("drain", 0, {4'h0, 32'ha0a0_a0a0 + i});
	endtask : t_fifo

	task t_par;
		for (int f = 2; f < 4; f++) begin
			wr(clss_pkg::CLSS_OFF_LOOP, f);
			push(32'h5e1f_0000 + f);
			wait_sig("par_loop", 1, {4'h0, 32'h5e1f_0000 + f});
		end
		wr(clss_pkg::CLSS_OFF_LOOP, 32'h0);
	endtask : t_par

	task t_rev;
		logic [3:0]  m, ek;
		logic [31:0] e;
		logic [31:0] inj_w;
		logic [3:0]  masks [3];
		masks = '{4'h1, 4'h6, 4'hf};
		// expectations use a local copy: inj_d only updates after this time step
		inj_w = 32'h5a69_783c;
		inj_en <= 1'b1;
		inj_d <= inj_w;
		foreach (masks[j]) begin
			m = masks[j];
			for (int b = 0; b < 4; b++) begin
				e[8*b +: 8] = m[b] ? inj_w[8*b +: 8] : clss_pkg::CLSS_IDLE_WORD[8*b +: 8];
				ek[b] = m[b] ? 1'b0 : clss_pkg::CLSS_IDLE_K[b];
			end
			wr(clss_pkg::CLSS_OFF_LOOP, {24'h0, m, 4'h0});
			wait_sig("rev_lanes", 0, {ek, e});
		end
		wr(clss_pkg::CLSS_OFF_LOOP, 32'h0);
		inj_en <= 1'b0;
	endtask : t_rev

	task t_sync;
		wr(clss_pkg::CLSS_OFF_L1, 32'h2);
		repeat (8) @(posedge pclk);
		wr(clss_pkg::CLSS_OFF_LOOP, 32'h1);
		// the enable is registered one edge after the field
		repeat (2) @(negedge pclk);
		chk("serial_on", {35'h0, serial_loop_en}, 36'h1);
		repeat (10) @(negedge pclk);
		chk("slave_quiet", {ser_tx_k, ser_tx_data}, 36'h0);
		chk("slave_unlocked", {35'h0, app_rx_valid}, 36'h0);
		// override set only for this layer 1 loop check
		wr(clss_pkg::CLSS_OFF_L1, 32'h3);
		wait_sig("forced_idle", 0, {4'h1, 32'h0000_00bc});
		wait_sig("self_lock", 2, 36'h1);
		wr(clss_pkg::CLSS_OFF_L1, 32'h0);
		wr(clss_pkg::CLSS_OFF_LOOP, 32'h0);
	endtask : t_sync

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{app_tx_data, app_tx_k, app_tx_valid, dir_wr_en, dir_wr_data} = '0;
		{inj_en, inj_d, err_total, check_count, cyc} = '0;
		ser_tx_ready = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_direct;
		t_fifo;
		t_par;
		t_rev;
		t_sync;
		end_of_test;
	end
endmodule : tb_top
`default_nettype wire
